// ---- rtl/ress_pkg.sv ----
// Purpose: shared constants and types of the rail sequencer and status block
// Assumes: 200 MHz system clock, 32-bit AHB-Lite register bus
// Notes:   offsets are byte addresses of aligned words

package ress_pkg;

  // ---------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------
  localparam int CLK_HZ          = 200_000_000;
  localparam int CHG_PWM_HZ      = 35_000;
  // nearest lower whole cycle count of one 35 kHz period
  localparam int CHG_PWM_CYC     = CLK_HZ / CHG_PWM_HZ;
  // pwm periods between swaps of the low and high duty
  localparam int CHG_ALT_PERIODS = 35;

  // ---------------------------------------------------------------------
  // rails
  // ---------------------------------------------------------------------
  localparam int         NUM_RAILS  = 3;
  localparam logic [1:0] RAIL_BUCK1 = 2'h0;
  localparam logic [1:0] RAIL_BUCK2 = 2'h1;
  localparam logic [1:0] RAIL_BB    = 2'h2;
  localparam logic [1:0] LAST_STEP  = 2'h2;

  // fixed 0.8 V servo point of the second buck, full-scale code
  localparam int         BUCK2_FB_MV   = 800;
  localparam logic [3:0] BUCK2_FB_CODE = 4'hF;

  // ---------------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_SETPT    = 8'h04;
  localparam logic [7:0] ADDR_STATUS   = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_CLR  = 8'h10;
  localparam logic [7:0] ADDR_IRQ_EN   = 8'h14;

  localparam int CTRL_EN_LSB     = 0;
  localparam int CTRL_LIM_LSB    = 4;
  localparam int SETPT_BUCK1_LSB = 0;
  localparam int SETPT_BB_LSB    = 4;

  localparam logic [1:0] LIM_100MA   = 2'h0;
  localparam logic [1:0] LIM_500MA   = 2'h1;
  localparam logic [1:0] LIM_1A      = 2'h2;
  localparam logic [1:0] LIM_SUSPEND = 2'h3;

  localparam logic [2:0] CTRL_EN_RST  = 3'h0;
  localparam logic [1:0] CTRL_LIM_RST = LIM_100MA;
  localparam logic [7:0] SETPT_RST    = 8'hFF;

  localparam int IRQ_W          = 5;
  localparam int IRQ_SEQ_DONE   = 0;
  localparam int IRQ_PG_RISE    = 1;
  localparam int IRQ_PG_FALL    = 2;
  localparam int IRQ_TEMP_PAUSE = 3;
  localparam int IRQ_CHG_CHANGE = 4;

  // ---------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    ORD_GND   = 2'h0,
    ORD_VOUT  = 2'h1,
    ORD_FLOAT = 2'h2
  } ress_order_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'h1,
    S_WAIT = 3'h2,
    S_DONE = 3'h4
  } ress_seq_t;

  typedef enum logic [1:0] {
    CHG_OFF    = 2'h0,
    CHG_ON     = 2'h1,
    CHG_BADBAT = 2'h2,
    CHG_TEMP   = 2'h3
  } ress_chg_t;

  typedef struct packed {
    logic [7:0] dutyA;
    logic [7:0] dutyB;
  } ress_duty_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       write;
    logic       valid;
  } ress_ahb_req_t;

  // duty in 1/256 of a period, indexed by ress_chg_t
  localparam ress_duty_t CHG_DUTY_TBL [4] = '{
    '{dutyA: 8'h00, dutyB: 8'h00},
    '{dutyA: 8'hFF, dutyB: 8'hFF},
    '{dutyA: 8'h20, dutyB: 8'hE0},
    '{dutyA: 8'h60, dutyB: 8'hA0}
  };

endpackage : ress_pkg

// ---- rtl/ress_sync.sv ----
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs are asynchronous levels
// Notes:   first stage feeds only the second

`timescale 1ns/1ps
`default_nettype none

module ress_sync
  import ress_pkg::*;
#(
  parameter int Width = 1
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [Width-1:0] asyncIn,
  output var  logic [Width-1:0] syncOut
);

  logic [Width-1:0] meta_q;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      meta_q  <= '0;
      syncOut <= '0;
    end
    else
    begin
      meta_q  <= asyncIn;
      syncOut <= meta_q;
    end
  end

endmodule : ress_sync

`default_nettype wire

// ---- rtl/ress_chg_pwm.sv ----
// Purpose: 35 kHz pulse train for the charger state pin
// Assumes: duty values in 1/256 of a period
// Notes:   swaps between two duties every CHG_ALT_PERIODS periods

`timescale 1ns/1ps
`default_nettype none

module ress_chg_pwm
  import ress_pkg::*;
#(
  parameter int PeriodCyc = CHG_PWM_CYC
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire ress_duty_t duty,
  output var  logic       pullLow
);

  logic [15:0] cnt_q;
  logic [7:0]  alt_q;
  logic        phase_q;
  logic        wrap;
  logic [7:0]  dutySel;
  logic [31:0] thresh;

  assign wrap    = (cnt_q == 16'(PeriodCyc - 1));
  assign dutySel = phase_q ? duty.dutyB : duty.dutyA;
  // full-scale duty means always on, not 255/256
  assign thresh  = (dutySel == 8'hFF) ? 32'(PeriodCyc)
                 : (32'(PeriodCyc) * 32'(dutySel)) >> 8;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cnt_q   <= 16'h0000;
      alt_q   <= 8'h00;
      phase_q <= 1'b0;
      pullLow <= 1'b0;
    end
    else
    begin
      cnt_q   <= wrap ? 16'h0000 : cnt_q + 16'h0001;           // R10
      alt_q   <= !wrap ? alt_q
               : (alt_q == 8'(CHG_ALT_PERIODS - 1)) ? 8'h00
               : alt_q + 8'h01;
      phase_q <= phase_q ^ (wrap && alt_q == 8'(CHG_ALT_PERIODS - 1));
      pullLow <= (32'(cnt_q) < thresh);                        // R10
    end
  end

  property p_period;
    @(posedge clk) disable iff (reset)
    wrap |=> cnt_q == 16'h0000;
  endproperty
  a_period: assert property (p_period) // R10
    else $error("pwm period did not wrap to zero");

endmodule : ress_chg_pwm

`default_nettype wire

// ---- rtl/ress_top.sv ----
// Purpose: rail enable sequencer, set-point, power-good and charger status
// Assumes: 200 MHz clk; pin inputs asynchronous; AHB-Lite register slave
// Notes:   zero-wait-state slave, always OKAY
//
// The placing of the registers and the AHB-Lite interface to the registers were decided locally.

`timescale 1ns/1ps
`default_nettype none

// What this block does
// R1 - order pin low: buck one, then buck two, then buck-boost
// R2 - order pin high: buck one, then buck-boost, then buck two
// R3 - order pin floating: buck-boost, then buck one, then buck two
// R4 - enable-everything input is active high and starts the sequence
// R5 - software may enable each regulator on its own
// R6 - all-settled output only when every enabled regulator has settled
// R7 - buck one and buck-boost take one of sixteen software set-points
// R8 - buck two keeps a fixed 0.8 V set-point
// R9 - charger state is one of four: on, off, bad battery, temperature
// R10 - charger state pin is a 35 kHz train of two duties
// R11 - charging pauses while temperature is out of range, then resumes
// R12 - software picks the input current limit and the block applies it
// R13 - two limit bits; one code suspends the input switcher
// R14 - next rail starts once previous settles; dropping enable clears them
// R15 - charger state to duty pattern comes from a constant table
module ress_top
  import ress_pkg::*;
#(
  parameter int PwmPeriodCyc = CHG_PWM_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic                 hready,
  input  wire logic [31:0]          hwdata,
  output var  logic [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  input  wire logic                 enableEverythingInput,
  input  wire logic                 orderSelectAtGround,
  input  wire logic                 orderSelectAtRail,
  input  wire logic [NUM_RAILS-1:0] railSettled,
  input  wire logic                 thermistorTooHot,
  input  wire logic                 thermistorTooCold,
  input  wire logic                 chargerActive,
  input  wire logic                 batteryUnresponsive,
  output logic [NUM_RAILS-1:0]      regEnable,
  output logic [3:0]                buckOneFeedback,
  output logic [3:0]                buckTwoFeedback,
  output logic [3:0]                buckBoostFeedback,
  output logic                      inputLimitSelectHigh,
  output logic                      inputLimitSelectLow,
  output logic                      switcherSuspend,
  output logic                      chargePause,
  output logic                      allRailsSettledOutput,
  output logic                      allRailsSettledOe,
  output logic                      chargerStateOutput,
  output logic                      chargerStateOe,
  output logic                      irq
);

  // ---------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------
  localparam int PinW = NUM_RAILS + 7;

  logic [PinW-1:0]      pinsS;
  logic                 enAllS;
  logic                 ordGndS;
  logic                 ordRailS;
  logic [NUM_RAILS-1:0] settledS;
  logic                 hotS;
  logic                 coldS;
  logic                 chgActS;
  logic                 badBatS;

  ress_sync #(
    .Width   (PinW)
  ) u_sync (
    .clk     (clk),
    .reset   (reset),
    .asyncIn ({enableEverythingInput, orderSelectAtGround,
               orderSelectAtRail, railSettled, thermistorTooHot,
               thermistorTooCold, chargerActive, batteryUnresponsive}),
    .syncOut (pinsS)
  );

  assign {enAllS, ordGndS, ordRailS, settledS, hotS, coldS, chgActS,
          badBatS} = pinsS;

  // ---------------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------------
  ress_ahb_req_t        req_q;
  logic [2:0]           ctrlEn_q;
  logic [1:0]           ctrlLim_q;
  logic [7:0]           setpt_q;
  logic [IRQ_W-1:0]     irqStat_q;
  logic [IRQ_W-1:0]     irqEn_q;
  logic [IRQ_W-1:0]     irqEvt;
  logic [IRQ_W-1:0]     irqClr;
  logic                 addrTake;
  logic                 wrPhase;
  logic [31:0]          rdMux;
  logic [31:0]          statusWord;

  assign addrTake  = hsel && htrans[1] && hready && (hsize == 3'h2);
  assign wrPhase   = req_q.valid && req_q.write;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign irqClr    = (wrPhase && req_q.addr == ADDR_IRQ_CLR)
                   ? hwdata[IRQ_W-1:0] : '0;

  // read data is captured in the address phase, so status is one edge old
  assign rdMux =
      (haddr[7:0] == ADDR_CTRL)     ? {26'h0, ctrlLim_q, 1'b0, ctrlEn_q}
    : (haddr[7:0] == ADDR_SETPT)    ? {24'h0, setpt_q}
    : (haddr[7:0] == ADDR_STATUS)   ? statusWord
    : (haddr[7:0] == ADDR_IRQ_STAT) ? {27'h0, irqStat_q}
    : (haddr[7:0] == ADDR_IRQ_EN)   ? {27'h0, irqEn_q}
    : 32'h0000_0000;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      req_q  <= '0;
      hrdata <= 32'h0000_0000;
    end
    else if (hready)
    begin
      req_q  <= '{addr: haddr[7:0], write: hwrite, valid: addrTake};
      hrdata <= (addrTake && !hwrite && haddr[31:8] == 24'h0)
              ? rdMux : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ctrlEn_q  <= CTRL_EN_RST;
      ctrlLim_q <= CTRL_LIM_RST;
      setpt_q   <= SETPT_RST;
      irqEn_q   <= '0;
    end
    else if (wrPhase)
    begin
      if (req_q.addr == ADDR_CTRL)
      begin
        ctrlEn_q  <= hwdata[CTRL_EN_LSB +: 3];                   // R5
        ctrlLim_q <= hwdata[CTRL_LIM_LSB +: 2];                  // R12
      end
      if (req_q.addr == ADDR_SETPT)
        setpt_q <= hwdata[7:0];                                  // R7
      if (req_q.addr == ADDR_IRQ_EN)
        irqEn_q <= hwdata[IRQ_W-1:0];
    end
  end

  // ---------------------------------------------------------------------
  // enable sequencer
  // ---------------------------------------------------------------------
  ress_seq_t            state_q;
  ress_order_t          ord_q;
  ress_order_t          ordPin;
  logic [1:0]           step_q;
  logic [NUM_RAILS-1:0] seqEn_q;
  logic [1:0]           curRail;
  logic                 stepDone;

  // rail brought up at a given step of a given order
  function automatic logic [1:0] railAt(ress_order_t o, logic [1:0] s);
    logic [1:0] r;
    r = RAIL_BUCK1;
    case (o)
      ORD_VOUT:  r = (s == 2'h0) ? RAIL_BUCK1                    // R2
                   : (s == 2'h1) ? RAIL_BB : RAIL_BUCK2;
      ORD_FLOAT: r = (s == 2'h0) ? RAIL_BB                       // R3
                   : (s == 2'h1) ? RAIL_BUCK1 : RAIL_BUCK2;
      default:   r = (s == 2'h0) ? RAIL_BUCK1                    // R1
                   : (s == 2'h1) ? RAIL_BUCK2 : RAIL_BB;
    endcase
    return r;
  endfunction : railAt

  assign ordPin   = ordGndS ? ORD_GND : ordRailS ? ORD_VOUT : ORD_FLOAT;
  assign curRail  = railAt(ord_q, step_q);
  assign stepDone = settledS[curRail];                           // R14

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_q <= S_IDLE;
      ord_q   <= ORD_GND;
      step_q  <= 2'h0;
      seqEn_q <= '0;
    end
    else
    begin
      case (state_q)
        S_IDLE:
          if (enAllS)                                            // R4
          begin
            state_q <= S_WAIT;
            ord_q   <= ordPin;
            step_q  <= 2'h0;
            seqEn_q <= NUM_RAILS'(1) << railAt(ordPin, 2'h0);
          end
        S_WAIT:
          if (!enAllS)
          begin
            state_q <= S_IDLE;
            seqEn_q <= '0;                                       // R14
          end
          else if (stepDone && step_q == LAST_STEP)
            state_q <= S_DONE;
          else if (stepDone)
          begin
            step_q  <= step_q + 2'h1;
            seqEn_q <= seqEn_q
                     | (NUM_RAILS'(1) << railAt(ord_q, step_q + 2'h1));
          end
        S_DONE:
          if (!enAllS)
          begin
            state_q <= S_IDLE;
            seqEn_q <= '0;                                       // R14
          end
        default:
        begin
          state_q <= S_IDLE;
          seqEn_q <= '0;
        end
      endcase
    end
  end

  assign regEnable = seqEn_q | ctrlEn_q;                         // R5

  // ---------------------------------------------------------------------
  // power good, set-points, input limit
  // ---------------------------------------------------------------------
  logic pg_q;
  logic pgNow;

  // held low mid-sequence so it can serve as a processor reset
  assign pgNow = (regEnable != '0) && (state_q != S_WAIT)
              && ((regEnable & ~settledS) == '0);                // R6

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      pg_q <= 1'b0;
    else
      pg_q <= pgNow;
  end

  assign allRailsSettledOutput = 1'b0;
  assign allRailsSettledOe     = !pg_q;                          // R6
  assign buckOneFeedback       = setpt_q[SETPT_BUCK1_LSB +: 4]; // R7
  assign buckBoostFeedback     = setpt_q[SETPT_BB_LSB +: 4];    // R7
  assign buckTwoFeedback       = BUCK2_FB_CODE;                  // R8
  assign inputLimitSelectHigh  = ctrlLim_q[1];                   // R13
  assign inputLimitSelectLow   = ctrlLim_q[0];                   // R13
  assign switcherSuspend       = (ctrlLim_q == LIM_SUSPEND);     // R13

  // ---------------------------------------------------------------------
  // charger status
  // ---------------------------------------------------------------------
  ress_chg_t chg_q;
  ress_chg_t chgNow;
  logic      tempOut;
  logic      pwmLow;

  assign tempOut = hotS || coldS;
  assign chgNow  = tempOut ? CHG_TEMP                            // R9
                 : badBatS ? CHG_BADBAT
                 : chgActS ? CHG_ON : CHG_OFF;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      chg_q       <= CHG_OFF;
      chargePause <= 1'b0;
    end
    else
    begin
      chg_q       <= chgNow;
      chargePause <= tempOut;                                    // R11
    end
  end

  ress_chg_pwm #(
    .PeriodCyc (PwmPeriodCyc)
  ) u_pwm (
    .clk       (clk),
    .reset     (reset),
    .duty      (CHG_DUTY_TBL[chg_q]),                            // R15
    .pullLow   (pwmLow)
  );

  assign chargerStateOutput = 1'b0;
  assign chargerStateOe     = pwmLow;                            // R10

  // ---------------------------------------------------------------------
  // interrupts and status word
  // ---------------------------------------------------------------------
  assign irqEvt[IRQ_SEQ_DONE]   = (state_q == S_WAIT) && enAllS && stepDone
                                && (step_q == LAST_STEP);
  assign irqEvt[IRQ_PG_RISE]    = pgNow && !pg_q;
  assign irqEvt[IRQ_PG_FALL]    = !pgNow && pg_q;
  assign irqEvt[IRQ_TEMP_PAUSE] = tempOut && !chargePause;
  assign irqEvt[IRQ_CHG_CHANGE] = (chgNow != chg_q);

  // a new event beats a clear in the same cycle
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      irqStat_q <= '0;
    else
      irqStat_q <= (irqStat_q & ~irqClr) | irqEvt;
  end

  assign irq = |(irqStat_q & irqEn_q);

  assign statusWord = {14'h0, chg_q, chargePause, pg_q, 1'b0, state_q,
                       ord_q, step_q, settledS, regEnable};

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  property p_order_gnd;
    @(posedge clk) disable iff (reset)
    (state_q == S_WAIT && ord_q == ORD_GND && step_q == 2'h1)
      |-> seqEn_q == 3'h3;
  endproperty
  a_order_gnd: assert property (p_order_gnd) // R1
    else $error("low order pin gave wrong second rail");

  property p_order_vout;
    @(posedge clk) disable iff (reset)
    (state_q == S_WAIT && ord_q == ORD_VOUT && step_q == 2'h1)
      |-> seqEn_q == 3'h5;
  endproperty
  a_order_vout: assert property (p_order_vout) // R2
    else $error("high order pin gave wrong second rail");

  property p_order_float;
    @(posedge clk) disable iff (reset)
    (state_q == S_WAIT && ord_q == ORD_FLOAT && step_q == 2'h0)
      |-> seqEn_q == 3'h4;
  endproperty
  a_order_float: assert property (p_order_float) // R3
    else $error("floating order pin did not start buck-boost");

  property p_start;
    @(posedge clk) disable iff (reset)
    (state_q == S_IDLE && enAllS) |=> (state_q == S_WAIT)
      ##0 $countones(seqEn_q) == 1;
  endproperty
  a_start: assert property (p_start) // R4
    else $error("enable did not start the sequence");

  property p_drop;
    @(posedge clk) disable iff (reset)
    (state_q != S_IDLE && !enAllS) |=> seqEn_q == '0;
  endproperty
  a_drop: assert property (p_drop) // R14
    else $error("sequenced rails stayed on after enable dropped");

  property p_pg;
    @(posedge clk) disable iff (reset)
    !allRailsSettledOe |-> $past((regEnable & ~settledS) == '0);
  endproperty
  a_pg: assert property (p_pg) // R6
    else $error("all-settled asserted with an unsettled rail");

  property p_setpt;
    @(posedge clk) disable iff (reset)
    (wrPhase && req_q.addr == ADDR_SETPT)
      |=> buckOneFeedback == $past(hwdata[3:0]);
  endproperty
  a_setpt: assert property (p_setpt) // R7
    else $error("buck one set-point not taken");

  property p_fixed;
    @(posedge clk) disable iff (reset)
    buckTwoFeedback == BUCK2_FB_CODE;
  endproperty
  a_fixed: assert property (p_fixed) // R8
    else $error("buck two set-point moved");

  property p_pause;
    @(posedge clk) disable iff (reset)
    tempOut |=> chargePause && chg_q == CHG_TEMP;
  endproperty
  a_pause: assert property (p_pause) // R11
    else $error("charging not paused on bad temperature");

  c_done: cover property (@(posedge clk) disable iff (reset)
    irqEvt[IRQ_SEQ_DONE]);
  c_float: cover property (@(posedge clk) disable iff (reset)
    state_q == S_DONE && ord_q == ORD_FLOAT);
  c_pg: cover property (@(posedge clk) disable iff (reset)
    $fell(allRailsSettledOe));

endmodule : ress_top

`default_nettype wire

// ---- tb/ress_rail_model.sv ----
// Purpose: rail settling model facing the sequencer outputs
// Assumes: one clock; a rail settles a fixed count after its enable
// Notes:   slow stretches settling so that waiting steps are seen

`timescale 1ns/1ps
`default_nettype none

module ress_rail_model (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       slow,
  input  wire logic [2:0] enable,
  output var  logic [2:0] settled
);
  // ---------------------------------------------------------------
  // settle counters
  // ---------------------------------------------------------------
  logic [3:0] cnt_q [3];

  always_ff @(posedge clk or posedge reset)
  begin
    for (int i = 0; i < 3; i++)
    begin
      if (reset || !enable[i])
        cnt_q[i] <= 4'h0;
      else if (cnt_q[i] != 4'hF)
        cnt_q[i] <= cnt_q[i] + 4'h1;
    end
  end

  // a disabled rail collapses on the next clock edge, keeping a stale good level for one cycle at most
  always_comb
  begin
    for (int i = 0; i < 3; i++)
      settled[i] = (cnt_q[i] >= (slow ? 4'hC : 4'h3));
  end
endmodule : ress_rail_model

`default_nettype wire

// ---- tb/tb_ress_top.sv ----
// Purpose: self-checking bench of the rail sequencer and status block
// Assumes: zero-wait AHB-Lite slave; pwm period shortened to 64 cycles
// Notes:   duty checked as a sum over one full 70-period swap pattern

`timescale 1ns/1ps
`default_nettype none

module tb_ress_top;
  import ress_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        clk, reset, hwrite, hreadyout, hresp, en, atGnd, atRail;
  logic        hot, cold, chgAct, badBat, slow, pOe, cOe, irq, pause;
  logic        limHi, limLo, susp, pOut, cOut;
  logic [1:0]  htrans;
  logic [2:0]  regEn, settled;
  logic [3:0]  fbOne, fbTwo, fbb;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  int          fails, n_tests;

  ress_top #(.PwmPeriodCyc(64)) u_ress_top (
    .clk(clk), .reset(reset), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .enableEverythingInput(en),
    .orderSelectAtGround(atGnd), .orderSelectAtRail(atRail),
    .railSettled(settled), .thermistorTooHot(hot),
    .thermistorTooCold(cold), .chargerActive(chgAct),
    .batteryUnresponsive(badBat), .regEnable(regEn),
    .buckOneFeedback(fbOne), .buckTwoFeedback(fbTwo),
    .buckBoostFeedback(fbb), .inputLimitSelectHigh(limHi),
    .inputLimitSelectLow(limLo), .switcherSuspend(susp),
    .chargePause(pause), .allRailsSettledOutput(pOut),
    .allRailsSettledOe(pOe), .chargerStateOutput(cOut),
    .chargerStateOe(cOe), .irq(irq));

  ress_rail_model u_ress_rail_model (
    .clk(clk), .reset(reset), .slow(slow), .enable(regEn),
    .settled(settled));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic test_done();
    if (fails == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic w();
    int i;
    i = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1)
    begin
      if (++i > 20)
      begin
        fails++;
        $display("CHECK FAILED %0t no hready", $time);
        test_done();
      end
      @(posedge clk);
    end
  endtask : w

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= 1'b1;
    w();
    htrans <= 2'h0;
    hwdata <= d;
    w();
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= 1'b0;
    w();
    htrans <= 2'h0;
    w();
    d = hrdata;
  endtask : rd

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    rd(ADDR_CTRL, rdv);
    chk(rdv, 32'h0);
    rd(ADDR_SETPT, rdv);
    chk(rdv, {24'h0, SETPT_RST});
    rd(8'h40, rdv);
    chk(rdv, 32'h0);
    chk(fbTwo, BUCK2_FB_CODE);
    chk({hreadyout, pOut, hresp, pOe, regEn}, 7'h48);
  endtask : t_reset

  task automatic t_order();
    logic [2:0] seen;
    logic [5:0] ord;
    logic [5:0] expOrd [3];
    int         k;
    expOrd = '{6'h24, 6'h18, 6'h12};
    for (int o = 0; o < 3; o++)
    begin
      atGnd  <= (o == 0);
      atRail <= (o == 1);
      slow   <= o[0];
      en     <= 1'b1;
      seen = 3'h0;
      ord  = 6'h0;
      k    = 0;
      for (int i = 0; i < 200 && k < 3; i++)
      begin
        @(posedge clk);
        for (int r = 0; r < 3; r++)
        begin
          if (regEn[r] === 1'b1 && !seen[r])
          begin
            ord[2*k +: 2] = r[1:0];
            k++;
            if (k > 1)
              chk(settled[ord[2*k-4 +: 2]], 1'b1);
          end
        end
        seen = regEn;
      end
      chk(ord, expOrd[o]);
      repeat (30) @(posedge clk);
      chk(pOe, 1'b0);
      en <= 1'b0;
      repeat (6) @(posedge clk);
      chk({pOe, regEn}, 4'h8);
    end
  endtask : t_order

  task automatic t_soft();
    slow <= 1'b1;
    wr(ADDR_CTRL, 32'h2);
    @(posedge clk);
    chk({pOe, regEn}, 4'hA);
    repeat (30) @(posedge clk);
    chk(pOe, 1'b0);
    wr(ADDR_CTRL, 32'h5);
    repeat (4) @(posedge clk);
    chk({pOe, regEn}, 4'hD);
    wr(ADDR_CTRL, 32'h0);
  endtask : t_soft

  task automatic t_setpt();
    for (int v = 0; v < 16; v++)
    begin
      wr(ADDR_SETPT, {24'h0, v[3:0], 4'hF - v[3:0]});
      @(posedge clk);
      chk({fbb, fbOne, fbTwo}, {v[3:0], ~v[3:0], BUCK2_FB_CODE});
    end
  endtask : t_setpt

  task automatic t_limit();
    for (int c = 0; c < 4; c++)
    begin
      wr(ADDR_CTRL, {26'h0, c[1:0], 4'h0});
      @(posedge clk);
      chk({susp, limHi, limLo}, {c == 3, c[1:0]});
    end
  endtask : t_limit

  task automatic t_irq();
    wr(ADDR_IRQ_CLR, 32'h1F);
    wr(ADDR_IRQ_EN, 32'h0);
    wr(ADDR_IRQ_STAT, 32'h0);
    hot <= 1'b1;
    repeat (8) @(posedge clk);
    chk({pause, irq}, 2'h2);
    wr(ADDR_IRQ_EN, 32'h8);
    @(posedge clk);
    chk(irq, 1'b1);
    rd(ADDR_IRQ_STAT, rdv);
    chk(rdv[IRQ_TEMP_PAUSE], 1'b1);
    wr(ADDR_IRQ_CLR, 32'h8);
    @(posedge clk);
    chk(irq, 1'b0);
    hot <= 1'b0;
    repeat (8) @(posedge clk);
    chk(pause, 1'b0);
  endtask : t_irq

  // state set as {cold, badBat, chgAct}; low-drive cycles over 4480
  task automatic meas(input logic [2:0] s, input int lo, input int hi);
    int n;
    {cold, badBat, chgAct} <= s;
    repeat (140) @(posedge clk);
    n = 0;
    repeat (4480)
    begin
      @(posedge clk);
      n += cOe;
    end
    chk(n >= lo && n <= hi, 1'b1);
    chk({cOut, pause}, {1'b0, s[2]});
    rd(ADDR_STATUS, rdv);
    chk(rdv[17:16], s[2] ? 2'h3 : s[1] ? 2'h2 : {1'b0, s[0]});
  endtask : meas

  task automatic t_charge();
    meas(3'h0, 0, 0);
    meas(3'h1, 4480, 4480);
    meas(3'h3, 2176, 2304);
    meas(3'h7, 2176, 2304);
    meas(3'h1, 4480, 4480);
  endtask : t_charge

  // ---------------------------------------------------------------
  // run
  // ---------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial
  begin
    fails   = 0;
    n_tests = 0;
    reset   = 1'b1;
    {htrans, hwrite, en, atGnd, atRail, hot} = '0;
    {cold, chgAct, badBat, slow} = '0;
    haddr   = '0;
    hwdata  = '0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_reset();
    t_order();
    t_soft();
    t_setpt();
    t_limit();
    t_irq();
    t_charge();
    test_done();
  end
endmodule : tb_ress_top

`default_nettype wire
